//--- core/disk_ctrl_pkg.sv
package disk_ctrl_pkg;
	// Clock and timing figures; counts of cycles are derived from them.
	localparam int CLK_NS      = 5;
	localparam int OVR_FM_NS   = 27000;
	localparam int OVR_MFM_NS  = 13000;
	localparam int MS_NS       = 1000000;
	localparam int OVR_FM_CYC  = OVR_FM_NS / CLK_NS;
	localparam int OVR_MFM_CYC = OVR_MFM_NS / CLK_NS;
	localparam int MS_CYC      = MS_NS / CLK_NS;
	localparam int UNLOAD_STEP_MS = 16;
	localparam int HLT_STEP_MS = 2;
	localparam int BASE_LEN    = 128;

	// Command sequence layout: byte index of each field.
	localparam logic [3:0] CMD_BYTES = 4'h9;
	localparam int IX_OP  = 0;
	localparam int IX_SEL = 1;
	localparam int IX_C   = 2;
	localparam int IX_H   = 3;
	localparam int IX_R   = 4;
	localparam int IX_N   = 5;
	localparam int IX_FINAL   = 6;
	localparam int IX_SHORT   = 8;
	localparam int B0_MULTI   = 7;
	localparam int B0_DENSITY = 6;
	localparam int B0_SKIP    = 5;
	localparam logic [4:0] OP_RD     = 5'h06;
	localparam logic [4:0] OP_RD_DEL = 5'h0c;
	localparam logic [4:0] OP_WR     = 5'h05;
	localparam logic [4:0] OP_WR_DEL = 5'h09;

	// Status field positions and codes.
	localparam logic [1:0] IC_NORMAL = 2'h0;
	localparam logic [1:0] IC_ABN    = 2'h1;
	localparam int S1_ID_CRC    = 5;
	localparam int S1_OVERRUN   = 4;
	localparam int S1_NO_DATA   = 2;
	localparam int S2_CTRL_MARK = 6;
	localparam int S2_DATA_CRC  = 5;

	// Register map on the AXI4-Lite slave.
	localparam logic [7:0] ADDR_CMD  = 8'h00;
	localparam logic [7:0] ADDR_CFG  = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_RES  = 8'h0c;
	localparam logic [31:0] CFG_RESET = 32'h0000_0011;
	localparam int CFG_UNLOAD_LSB = 0;
	localparam int CFG_HLT_LSB = 4;
	localparam int STAT_BUSY   = 31;
	localparam int STAT_LOADED = 30;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		PH_IDLE, PH_SETTLE, PH_SEARCH, PH_MARK, PH_READ, PH_SKIP, PH_WRITE
	} phase_t;

	typedef struct packed {
		logic [7:0] c;
		logic [7:0] h;
		logic [7:0] r;
		logic [7:0] n;
	} id_field_t;

	typedef struct packed {
		logic       index;
		logic       id_valid;
		id_field_t  id;
		logic       id_crc_ok;
		logic       mark_valid;
		logic       mark_deleted;
		logic       rd_valid;
		logic [7:0] rd_byte;
		logic       field_end;
		logic       crc_ok;
		logic       wr_req;
	} drv_in_t;

	typedef struct packed {
		logic       head_load;
		logic       head_sel;
		logic       wr_start;
		logic       wr_deleted;
		logic       wr_valid;
		logic [7:0] wr_byte;
	} drv_out_t;
endpackage : disk_ctrl_pkg

//--- core/floppy_sector_read_write_exec.sv
// Functional notes
// [R01] Nine command bytes before the command starts.
// [R02] Load head, wait settle, then scan IDs.
// [R03] Matching sector number sends data bytes to host.
// [R04] Sector done: sector number plus one, continue.
// [R05] Host raises terminal count with last acknowledge.
// [R06] Terminal count stops delivery; finish sector, CRC.
// [R07] Multi-track spans both sides, one cylinder only.
// [R08] Size zero: short length limits delivered bytes.
// [R09] Size nonzero: host sets short length FF.
// [R10] Head stays loaded; early command skips settle.
// [R11] Two index pulses unmatched: no data, abnormal.
// [R12] ID CRC sets error; data CRC also terminates.
// [R13] Unwanted deleted mark, skip clear: read, flag, stop.
// [R14] Skip set: bypass deleted sector, no CRC.
// [R15] Read byte not serviced in time: overrun.
// [R16] Result: sector plus one, or cylinder plus one.
// [R17] Multi-track end: flip head bit, cylinder rule.
// [R18] Write starts when all four ID bytes match.
// [R19] Write continues to count; pad with zeros.
// [R20] Write ID CRC error: flag and abnormal stop.
// [R21] Host supplies write bytes in time, else overrun.
// [R22] Deleted write records deleted data mark.
// [R23] Deleted read: normal mark handled as control mark.
// [R24] Stop after the final sector of the track.
// [R25] Head unload interval in 16 ms steps.
// [R26] Overrun timer restarts on every host byte.
`timescale 1ns/1ps
`default_nettype none
module floppy_sector_read_write_exec
	import disk_ctrl_pkg::*;
#(
	parameter int OVR_FM_LIM = OVR_FM_CYC,
	parameter int MS_LIM     = MS_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             host_req,
	input  wire logic        host_dack,
	input  wire logic        terminal_count,
	output logic [7:0]       host_rdata,
	input  wire logic [7:0]  host_wdata,
	input  wire drv_in_t     drv_in,
	output drv_out_t         drv_out
);

	typedef struct packed {
		phase_t          ph;
		logic [8:0][7:0] cmd;
		logic [3:0]      nbytes;
		logic [31:0]     cfg;
		logic [7:0]      status_zero;
		logic [7:0]      status_one;
		logic [7:0]      status_two;
		id_field_t       res;
		logic            busy;
		logic            loaded;
		logic [19:0]     ms_div;
		logic [7:0]      ms_cnt;
		logic [12:0]     ovr;
		logic            idx;
		logic [13:0]     bcnt;
		logic            term_seen;
		logic            ctrl_mark;
		logic            hreq;
		logic [7:0]      hdata;
		logic [7:0]      wbuf;
		logic            have;
		drv_out_t        dout;
		logic            aw_got;
		logic            w_got;
		logic [7:0]      awa;
		logic [31:0]     wd;
		logic [3:0]      ws;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
	} state_t;

	state_t q;
	state_t d;
	logic        tick;
	logic        start;
	logic [13:0] rd_len;
	logic [12:0] ovr_lim;
	logic [7:0]  unl_lim;
	logic        is_wr;
	logic        mark_bad;

	// Sector length: short length for size zero, else 128 shifted by size.
	function automatic logic [13:0] sec_len(input logic [7:0] n,
		input logic [7:0] slen);
		if (n == 8'h00) begin
			sec_len = {6'h00, slen};
		end else begin
			sec_len = 14'(BASE_LEN << n[2:0]);
		end
	endfunction : sec_len

	// ID reported after the last sector handed over.
	function automatic id_field_t end_id(input id_field_t i,
		input logic [7:0] last_r, input logic multi);
		end_id = i;
		if (i.r != last_r) begin
			end_id.r = i.r + 8'h01; // R16
		end else begin
			end_id.r = 8'h01; // R16 R17
			if (multi) begin
				end_id.h = {i.h[7:1], ~i.h[0]}; // R17
			end
			if (!multi || i.h[0]) begin
				end_id.c = i.c + 8'h01; // R16 R17
			end
		end
	endfunction : end_id

	// Bus handshakes are combinational; payloads come from the state.
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready  = !q.w_got && !q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign host_req      = q.hreq;
	assign host_rdata    = q.hdata;
	assign drv_out       = q.dout;

	// Decoded command attributes and limits.
	assign tick    = q.ms_div == 20'(MS_LIM - 1);
	assign rd_len  = sec_len(q.cmd[IX_N], q.cmd[IX_SHORT]);
	assign ovr_lim = q.cmd[IX_OP][B0_DENSITY] ? 13'(OVR_MFM_CYC)
		: 13'(OVR_FM_LIM);
	assign unl_lim = 8'(q.cfg[CFG_UNLOAD_LSB+:4] * UNLOAD_STEP_MS); // R25
	assign is_wr   = q.cmd[IX_OP][4:0] == OP_WR
		|| q.cmd[IX_OP][4:0] == OP_WR_DEL;
	// A mark is unwanted when it is deleted for a plain read, normal otherwise.
	assign mark_bad = drv_in.mark_deleted
		== (q.cmd[IX_OP][4:0] != OP_RD_DEL); // R13 R23

	// Next state: sequencer, timers and bus slave.
	always_comb begin
		logic      fin;
		logic      fin_abn;
		logic      fin_done;
		logic      adv;
		logic      tcs;
		id_field_t cur;
		fin      = 1'b0;
		fin_abn  = 1'b0;
		fin_done = 1'b0;
		adv      = 1'b0;
		tcs      = q.term_seen || (host_dack && q.hreq && terminal_count);
		cur      = {q.cmd[IX_C], q.cmd[IX_H], q.cmd[IX_R], q.cmd[IX_N]};
		d        = q;
		start    = 1'b0;
		d.ms_div = tick ? 20'h00000 : q.ms_div + 20'h00001;
		d.dout.wr_start = 1'b0;
		d.dout.wr_valid = 1'b0;
		if (q.hreq) begin
			d.ovr = q.ovr + 13'h0001;
			if (q.ovr >= ovr_lim - 13'h0001) begin
				d.status_one[S1_OVERRUN] = 1'b1; // R15 R21
				fin     = 1'b1;
				fin_abn = 1'b1;
			end
		end
		unique case (q.ph)
			PH_IDLE: begin
				if (q.loaded && tick) begin
					d.ms_cnt = q.ms_cnt + 8'h01;
					if (q.ms_cnt + 8'h01 >= unl_lim) begin
						d.loaded = 1'b0; // R10 R25
					end
				end
			end
			PH_SETTLE: begin
				if (tick) begin
					d.ms_cnt = q.ms_cnt + 8'h01;
					if (q.ms_cnt + 8'h01 >=
						8'(q.cfg[CFG_HLT_LSB+:7] * HLT_STEP_MS)) begin
						d.ph = PH_SEARCH; // R02
					end
				end
			end
			PH_SEARCH: begin
				if (drv_in.index) begin
					d.idx = 1'b1;
					if (q.idx) begin
						d.status_one[S1_NO_DATA] = 1'b1; // R11
						fin     = 1'b1;
						fin_abn = 1'b1;
					end
				end
				if (drv_in.id_valid && !drv_in.id_crc_ok) begin
					d.status_one[S1_ID_CRC] = 1'b1; // R12 R20
					fin     = 1'b1;
					fin_abn = 1'b1;
				end else if (drv_in.id_valid && is_wr
					&& drv_in.id == cur) begin
					d.ph = PH_WRITE; // R18
					d.dout.wr_start   = 1'b1;
					d.dout.wr_deleted =
						q.cmd[IX_OP][4:0] == OP_WR_DEL; // R22
					d.bcnt = 14'h0000;
					d.hreq = 1'b1;
					d.ovr  = 13'h0000;
					d.have = 1'b0;
					d.idx  = 1'b0;
				end else if (drv_in.id_valid && !is_wr
					&& drv_in.id.r == q.cmd[IX_R]) begin
					d.ph  = PH_MARK; // R03
					d.idx = 1'b0;
				end
			end
			PH_MARK: begin
				if (drv_in.mark_valid) begin
					d.bcnt = 14'h0000;
					if (mark_bad && q.cmd[IX_OP][B0_SKIP]) begin
						d.ph = PH_SKIP; // R14 R23
					end else begin
						d.ph = PH_READ;
						if (mark_bad) begin
							d.ctrl_mark = 1'b1; // R13 R23
							d.status_two[S2_CTRL_MARK] = 1'b1;
						end
					end
				end
			end
			PH_SKIP: begin
				if (drv_in.field_end) begin
					adv = 1'b1; // R14
				end
			end
			PH_READ: begin
				if (host_dack && q.hreq) begin
					d.hreq = 1'b0;
					d.ovr  = 13'h0000; // R26
				end
				d.term_seen = tcs;
				if (drv_in.rd_valid) begin
					d.bcnt = q.bcnt + 14'h0001;
					if (q.bcnt < rd_len && !tcs) begin
						d.hdata = drv_in.rd_byte; // R03 R06 R08
						d.hreq  = 1'b1;
						d.ovr   = 13'h0000; // R26
					end
				end
				if (drv_in.field_end) begin
					if (!drv_in.crc_ok) begin
						d.status_one[S1_ID_CRC] = 1'b1; // R12
						d.status_two[S2_DATA_CRC] = 1'b1;
						fin     = 1'b1;
						fin_abn = 1'b1;
					end else if (q.ctrl_mark || tcs) begin
						fin      = 1'b1; // R06 R13
						fin_done = 1'b1;
					end else begin
						adv = 1'b1;
					end
				end
			end
			PH_WRITE: begin
				d.term_seen = tcs;
				if (host_dack && q.hreq) begin
					d.wbuf = host_wdata;
					d.have = 1'b1;
					d.hreq = 1'b0;
					d.ovr  = 13'h0000; // R26
				end
				if (drv_in.wr_req) begin
					d.dout.wr_valid = 1'b1;
					d.dout.wr_byte  = q.have ? q.wbuf : 8'h00; // R19
					d.have = 1'b0;
					d.bcnt = q.bcnt + 14'h0001;
					if (!tcs && q.bcnt + 14'h0001 < rd_len) begin
						d.hreq = 1'b1;
					end
					if (q.bcnt + 14'h0001 >= rd_len) begin
						d.hreq = 1'b0;
						if (tcs) begin
							fin      = 1'b1; // R19
							fin_done = 1'b1;
						end else begin
							adv = 1'b1;
						end
					end
				end
			end
		endcase
		// Move to the next sector, the other side, or stop at track end.
		if (adv && !fin) begin
			d.ph  = PH_SEARCH;
			d.idx = 1'b0;
			if (q.cmd[IX_R] != q.cmd[IX_FINAL]) begin
				d.cmd[IX_R] = q.cmd[IX_R] + 8'h01; // R04 R19
			end else if (q.cmd[IX_OP][B0_MULTI] && !q.cmd[IX_H][0]) begin
				d.cmd[IX_R] = 8'h01; // R07
				d.cmd[IX_H] = {q.cmd[IX_H][7:1], 1'b1};
			end else begin
				fin      = 1'b1; // R07 R24
				fin_done = 1'b1;
			end
		end
		if (fin) begin
			d.ph     = PH_IDLE;
			d.busy   = 1'b0;
			d.hreq   = 1'b0;
			d.ms_cnt = 8'h00;
			d.status_zero[7:6] = fin_abn ? IC_ABN : IC_NORMAL; // R11 R12
			d.res = fin_done ? end_id(cur, q.cmd[IX_FINAL],
				q.cmd[IX_OP][B0_MULTI]) : cur; // R16 R17
		end
		// Write channel: both halves taken in any order, then answered.
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.awa    = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.wd    = s_axi_wdata;
			d.ws    = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = RESP_OKAY;
			case (q.awa)
				ADDR_CMD: begin
					if (q.ws[0] && q.ph == PH_IDLE) begin
						d.cmd[q.nbytes] = q.wd[7:0];
						d.nbytes = q.nbytes + 4'h1;
						if (q.nbytes == CMD_BYTES - 4'h1) begin
							start = 1'b1; // R01
						end
					end
				end
				ADDR_CFG: begin
					for (int i = 0; i < 4; i++) begin
						if (q.ws[i]) begin
							d.cfg[8*i+:8] = q.wd[8*i+:8];
						end
					end
				end
				ADDR_STAT, ADDR_RES: begin
				end
				default: begin
					d.bresp = RESP_DECERR;
				end
			endcase
		end
		// Command start: a loaded head skips the settling wait.
		if (start) begin
			d.nbytes  = 4'h0;
			d.busy    = 1'b1;
			d.status_zero = {5'h00, d.cmd[IX_SEL][2:0]};
			d.status_one  = 8'h00;
			d.status_two  = 8'h00;
			d.ph      = q.loaded ? PH_SEARCH : PH_SETTLE; // R02 R10
			d.loaded  = 1'b1;
			d.ms_cnt  = 8'h00;
			d.idx     = 1'b0;
			d.term_seen = 1'b0;
			d.ctrl_mark = 1'b0;
		end
		d.dout.head_load = d.loaded;
		d.dout.head_sel  = d.cmd[IX_H][0];
		// Read channel answers one cycle after the address is taken.
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp  = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CMD:  d.rdata = {28'h0000000, q.nbytes};
				ADDR_CFG:  d.rdata = q.cfg;
				ADDR_STAT: d.rdata = {q.busy, q.loaded, 6'h00,
					q.status_two, q.status_one, q.status_zero};
				ADDR_RES:  d.rdata = q.res;
				default: begin
					d.rdata = 32'h00000000;
					d.rresp = RESP_DECERR;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			q     <= '0;
			q.ph  <= PH_IDLE;
			q.cfg <= CFG_RESET;
		end else begin
			q <= d;
		end
	end

	// Checks on the sequencer.
	settle_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R02
		(q.ph == PH_SETTLE && !tick) |=> q.ph == PH_SETTLE)
		else $error("settle left without a millisecond tick");
	rd_deliver_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R03
		(q.ph == PH_READ && drv_in.rd_valid && q.bcnt < rd_len
		&& !q.term_seen && !terminal_count && !q.hreq && !drv_in.field_end)
		|=> host_req && host_rdata == $past(drv_in.rd_byte))
		else $error("read byte not offered to host");
	count_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R06
		(q.ph == PH_READ && q.term_seen) |=> !$rose(host_req))
		else $error("byte offered after terminal count");
	short_len_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R08
		(q.ph == PH_READ && drv_in.rd_valid && q.bcnt >= rd_len)
		|=> $stable(host_rdata))
		else $error("byte beyond short length delivered");
	no_data_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
		(q.ph == PH_SEARCH && drv_in.index && q.idx && q.hreq == 1'b0)
		|=> q.ph == PH_IDLE && q.status_one[S1_NO_DATA]
		&& q.status_zero[7:6] == IC_ABN)
		else $error("second index did not end the command");
	id_crc_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
		(q.ph == PH_SEARCH && drv_in.id_valid && !drv_in.id_crc_ok)
		|=> q.status_one[S1_ID_CRC] && !q.busy
		&& q.status_zero[7:6] == IC_ABN)
		else $error("ID CRC error not reported");
	skip_mark_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
		(q.ph == PH_MARK && drv_in.mark_valid && mark_bad
		&& q.cmd[IX_OP][B0_SKIP] && !q.hreq) |=> q.ph == PH_SKIP)
		else $error("deleted sector not skipped");
	ctrl_mark_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
		(q.ph == PH_MARK && drv_in.mark_valid && mark_bad
		&& !q.cmd[IX_OP][B0_SKIP] && !q.hreq)
		|=> q.ph == PH_READ && q.status_two[S2_CTRL_MARK])
		else $error("control mark not flagged");
	overrun_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
		(q.hreq && q.ovr >= ovr_lim - 13'h0001)
		|=> q.status_one[S1_OVERRUN] && q.ph == PH_IDLE && !host_req)
		else $error("overrun not flagged");
	loaded_skip_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
		(start && q.loaded) |=> q.ph == PH_SEARCH ##1 q.dout.head_load)
		else $error("settle not skipped with head loaded");
	unload_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R25
		$fell(q.loaded) |-> $past(q.ms_cnt) + 8'h01 >= unl_lim)
		else $error("head unloaded too early");
	pad_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R19
		(q.ph == PH_WRITE && drv_in.wr_req && !q.have)
		|=> drv_out.wr_valid && drv_out.wr_byte == 8'h00)
		else $error("write remainder not zero padded");

	start_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		start ##[1:1000] q.ph == PH_READ);
	side_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		q.ph == PH_SEARCH && $past(q.ph) != PH_SEARCH && q.cmd[IX_H][0]
		&& q.cmd[IX_R] == 8'h01 && q.cmd[IX_OP][B0_MULTI]);
	write_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		$fell(q.busy) && is_wr && !q.status_zero[6]);
	skip_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		q.ph == PH_SKIP);

endmodule : floppy_sector_read_write_exec
`default_nettype wire

//--- sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       core_clk,
	input  wire logic       host_req,
	input  wire logic [7:0] host_rdata,
	output var logic        host_dack,
	output var logic        terminal_count,
	output var logic [7:0]  host_wdata
);
	int         delay;
	int         stop_at;
	int         n_done;
	int         wait_n;
	logic [7:0] got[$];

	// Idle values before the first request arrives.
	initial begin
		delay = 2;
		stop_at = 0;
		n_done = 0;
		wait_n = 0;
		host_dack = 1'b0;
		terminal_count = 1'b0;
		host_wdata = 8'h00;
	end

	// Services each pending byte after a set delay; a negative delay stalls.
	always @(posedge core_clk) begin
		host_dack <= 1'b0;
		terminal_count <= 1'b0;
		host_wdata <= ~host_wdata; // The bus is not held between transfers.
		if (host_req && !host_dack && delay >= 0) begin
			if (wait_n < delay) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				n_done <= n_done + 1;
				got.push_back(host_rdata);
				host_dack <= 1'b1;
				host_wdata <= 8'ha1 + 8'(n_done);
				terminal_count <= (n_done + 1 == stop_at);
			end
		end
	end
endmodule : host_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import disk_ctrl_pkg::*;;
	logic        core_clk, reset_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, host_rdata, host_wdata;
	logic [31:0] s_axi_wdata, s_axi_rdata, st, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, host_req, host_dack;
	logic        terminal_count, del_seen;
	drv_in_t     drv_in, v;
	drv_out_t    drv_out;
	int          n_mismatch, check_count, n_start;
	logic [7:0]  wq[$];

	floppy_sector_read_write_exec #(.OVR_FM_LIM(50), .MS_LIM(20))
	floppy_sector_read_write_exec_i (
		.core_clk(core_clk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .host_req(host_req),
		.host_dack(host_dack), .terminal_count(terminal_count),
		.host_rdata(host_rdata), .host_wdata(host_wdata),
		.drv_in(drv_in), .drv_out(drv_out));

	host_model host_model_i (
		.core_clk(core_clk), .host_req(host_req), .host_rdata(host_rdata),
		.host_dack(host_dack), .terminal_count(terminal_count),
		.host_wdata(host_wdata));

	// Clock at 200 MHz.
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Collects what the block writes to the drive.
	always @(posedge core_clk) begin
		if (drv_out.wr_valid) wq.push_back(drv_out.wr_byte);
		if (drv_out.wr_start) begin
			n_start++;
			del_seen = drv_out.wr_deleted;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	// One write, both halves offered together; waits for the response.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] w,
		output logic [1:0] r);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (int t = 0; t < 100; t++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			r = s_axi_bresp;
			if (s_axi_bvalid === 1'b1) break;
			if (t == 99) chk(1, 0);
		end
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] q,
		output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		for (int t = 0; t < 100; t++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			q = s_axi_rdata;
			r = s_axi_rresp;
			if (s_axi_rvalid === 1'b1) break;
			if (t == 99) chk(1, 0);
		end
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// Nine command bytes; busy must stay low until the last one.
	task automatic cmd(input logic [7:0] b0, c, r, last, len);
		logic [7:0] b[9];
		b = '{b0, 8'h00, c, 8'h00, r, 8'h00, last, 8'h00, len};
		foreach (b[i]) begin
			if (i == 8) begin
				axi_rd(ADDR_STAT, st, rr);
				chk(st[STAT_BUSY], 1'b0);
			end
			axi_wr(ADDR_CMD, {24'h0, b[i]}, rr);
		end
	endtask : cmd

	task automatic drv(input drv_in_t x);
		@(posedge core_clk);
		drv_in <= x;
		@(posedge core_clk);
		drv_in <= '0;
	endtask : drv

	task automatic send_id(input logic [7:0] c, h, r, input logic ok);
		drv_in_t x;
		x = '0;
		x.id_valid = 1'b1;
		x.id = {c, h, r, 8'h00};
		x.id_crc_ok = ok;
		drv(x);
	endtask : send_id

	// Mark, then nb bytes valued 10h upward, then the end of the field.
	task automatic send_data(input logic del, input int nb, input logic ok);
		drv_in_t x;
		x = '0;
		x.mark_valid = 1'b1;
		x.mark_deleted = del;
		drv(x);
		for (int i = 0; i < nb; i++) begin
			x = '0;
			x.rd_valid = 1'b1;
			x.rd_byte = 8'h10 + 8'(i);
			drv(x);
			tick(6);
		end
		x = '0;
		x.field_end = 1'b1;
		x.crc_ok = ok;
		drv(x);
	endtask : send_data

	task automatic settle();
		for (int t = 0; t < 300 && drv_out.head_load !== 1'b1; t++) tick(1);
		tick(60);
	endtask : settle

	task automatic wait_idle();
		for (int t = 0; t < 300; t++) begin
			axi_rd(ADDR_STAT, st, rr);
			if (st[STAT_BUSY] === 1'b0) return;
		end
		chk(1, 0);
	endtask : wait_idle

	task automatic host_set(input int dl, input int stop);
		host_model_i.delay = dl;
		host_model_i.stop_at = stop;
		host_model_i.n_done = 0;
		host_model_i.got.delete();
	endtask : host_set

	// Cuts the run short if a wait never ends.
	initial begin
		tick(60000);
		chk(1, 0);
		results();
	end

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		drv_in = '0;
		tick(20);
		reset_n <= 1'b1;
		axi_rd(ADDR_CFG, d, rr);
		chk(d, CFG_RESET);
		chk(rr, RESP_OKAY);
		axi_wr(8'h20, 32'h0, rr);
		chk(rr, RESP_DECERR);
		$display("test registers done");
		host_set(2, 0);
		cmd({3'b001, OP_RD}, 8'h03, 8'h01, 8'h02, 8'h04);
		settle();
		send_id(8'h03, 8'h00, 8'h01, 1'b1);
		send_data(1'b1, 8, 1'b0);
		send_id(8'h03, 8'h00, 8'h02, 1'b1);
		send_data(1'b0, 8, 1'b1);
		wait_idle();
		chk(st[23:0], 24'h0);
		chk(host_model_i.got.size(), 4);
		foreach (host_model_i.got[i]) chk(host_model_i.got[i], 8'h10 + i);
		axi_rd(ADDR_RES, d, rr);
		chk(d, 32'h04000100);
		chk(drv_out.head_load, 1'b1);
		tick(400);
		chk(drv_out.head_load, 1'b0);
		$display("test skip read done");
		host_set(2, 3);
		cmd({3'b100, OP_RD}, 8'h05, 8'h01, 8'h01, 8'h02);
		settle();
		send_id(8'h05, 8'h00, 8'h01, 1'b1);
		send_data(1'b0, 4, 1'b1);
		tick(4);
		chk(drv_out.head_sel, 1'b1);
		send_id(8'h05, 8'h01, 8'h01, 1'b1);
		send_data(1'b0, 4, 1'b1);
		wait_idle();
		chk(host_model_i.got.size(), 3);
		axi_rd(ADDR_RES, d, rr);
		chk(d, 32'h06000100);
		$display("test two sides done");
		cmd({3'b000, OP_RD}, 8'h03, 8'h07, 8'h07, 8'h02);
		settle();
		v = '0;
		v.index = 1'b1;
		drv(v);
		send_id(8'h03, 8'h00, 8'h01, 1'b1);
		drv(v);
		wait_idle();
		chk(st[23:0], {16'h0004, IC_ABN, 6'h00});
		cmd({3'b000, OP_RD}, 8'h03, 8'h01, 8'h01, 8'h02);
		settle();
		send_id(8'h03, 8'h00, 8'h01, 1'b1);
		send_data(1'b0, 4, 1'b0);
		wait_idle();
		chk(st[23:0], {16'h2020, IC_ABN, 6'h00});
		cmd({3'b000, OP_RD_DEL}, 8'h03, 8'h01, 8'h01, 8'h02);
		settle();
		send_id(8'h03, 8'h00, 8'h01, 1'b1);
		send_data(1'b0, 4, 1'b1);
		wait_idle();
		chk(st[23:16], 8'h40);
		host_set(-1, 0);
		cmd({3'b000, OP_RD}, 8'h03, 8'h01, 8'h01, 8'h02);
		settle();
		send_id(8'h03, 8'h00, 8'h01, 1'b1);
		v = '0;
		v.mark_valid = 1'b1;
		drv(v);
		v = '0;
		v.rd_valid = 1'b1;
		drv(v);
		tick(80);
		wait_idle();
		chk(st[15:0], {8'h10, IC_ABN, 6'h00});
		$display("test read errors done");
		for (int k = 0; k < 2; k++) begin
			host_set(1, 2);
			wq.delete();
			n_start = 0;
			cmd({3'b000, k ? OP_WR_DEL : OP_WR}, 8'h02, 8'h03, 8'h03, 8'h04);
			settle();
			v = '0;
			v.id_valid = 1'b1;
			v.id = 32'h02000301;
			v.id_crc_ok = 1'b1;
			drv(v);
			send_id(8'h02, 8'h00, 8'h03, 1'b1);
			tick(20);
			v = '0;
			v.wr_req = 1'b1;
			repeat (4) begin
				drv(v);
				tick(18);
			end
			wait_idle();
			chk(n_start, 1);
			chk(del_seen, k);
			chk(wq.size(), 4);
			foreach (wq[i]) chk(wq[i], i < 2 ? 8'ha1 + i : 8'h00);
			axi_rd(ADDR_RES, d, rr);
			chk(d, 32'h03000100);
		end
		$display("test writes done");
		results();
	end
endmodule : testbench
`default_nettype wire
